// ### hw/ulrr_cfg.svh
`ifndef ULRR_CFG_SVH
`define ULRR_CFG_SVH

// Command byte layout
`define ULRR_CMD_READ_TYPE 2'h3
`define ULRR_CMD_TYPE_HI 7
`define ULRR_CMD_TYPE_LO 6
`define ULRR_CMD_ADDR_HI 5
`define ULRR_ADDR_ESCAPE 6'h2F
`define ULRR_IDLE_BYTE 8'h00

// Status byte field positions
`define ULRR_STS_LINE_LO 0
`define ULRR_STS_VBUS_LO 2
`define ULRR_STS_EVT_LO 4
`define ULRR_STS_ID_BIT 6
`define ULRR_STS_ALT_BIT 7

// Status field encodings
`define ULRR_VBUS_BELOW_END 2'h0
`define ULRR_VBUS_SESS_LOW 2'h1
`define ULRR_VBUS_SESS_VALID 2'h2
`define ULRR_VBUS_VALID 2'h3
`define ULRR_EVT_NONE 2'h0
`define ULRR_EVT_RX_ACTIVE 2'h1
`define ULRR_EVT_RX_ERROR 2'h3
`define ULRR_EVT_DISCONNECT 2'h2

// Reset values
`define ULRR_DATA_RST 8'h00

`endif

// ### hw/ulrr_pkg.sv
package ulrr_pkg;

  typedef enum logic [7:0]
  {
    ULRR_IDLE = 8'h01,
    ULRR_CMD_WAIT = 8'h02,
    ULRR_CMD_ACK = 8'h04,
    ULRR_EXT_ADDR = 8'h08,
    ULRR_TURN_IN = 8'h10,
    ULRR_DRIVE = 8'h20,
    ULRR_TURN_OUT = 8'h40,
    ULRR_STS_SEND = 8'h80
  } ulrr_state_t;

endpackage

// ### hw/ulrr_sync.sv
module ulrr_sync
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // Levels
  input wire logic [10:0] async_in,
  output logic [10:0] sync_out
);

  logic [10:0] meta_r;

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      meta_r <= 11'h000;
      sync_out <= 11'h000;
    end
    else
    begin
      meta_r <= async_in;
      sync_out <= meta_r;
    end
  end

endmodule

// ### hw/ulrr_status_enc.sv
`include "ulrr_cfg.svh"

module ulrr_status_enc
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // Synchronised status levels
  input wire logic line_dp,
  input wire logic line_dm,
  input wire logic sess_end,
  input wire logic sess_vld,
  input wire logic vbus_vld,
  input wire logic rx_active,
  input wire logic rx_error,
  input wire logic host_disc,
  input wire logic id_level,
  input wire logic alt_int,
  // Encoded byte, registered
  output logic [7:0] sts_byte
);

  function automatic logic [1:0] vbus_code(input logic s_end, input logic s_vld, input logic v_vld);
    if (v_vld)
      return `ULRR_VBUS_VALID;
    else if (s_vld)
      return `ULRR_VBUS_SESS_VALID;
    else if (s_end)
      return `ULRR_VBUS_BELOW_END;
    else
      return `ULRR_VBUS_SESS_LOW;
  endfunction

  function automatic logic [1:0] evt_code(input logic act, input logic err, input logic disc);
    if (disc)
      return `ULRR_EVT_DISCONNECT;
    else if (act && err)
      return `ULRR_EVT_RX_ERROR;
    else if (act)
      return `ULRR_EVT_RX_ACTIVE;
    else
      return `ULRR_EVT_NONE;
  endfunction

  logic [7:0] sts_nxt;

  always_comb
  begin
    sts_nxt = 8'h00;
    sts_nxt[`ULRR_STS_LINE_LO] = line_dp;
    sts_nxt[`ULRR_STS_LINE_LO + 1] = line_dm;
    sts_nxt[`ULRR_STS_VBUS_LO +: 2] = vbus_code(sess_end, sess_vld, vbus_vld);
    sts_nxt[`ULRR_STS_EVT_LO +: 2] = evt_code(rx_active, rx_error, host_disc);
    sts_nxt[`ULRR_STS_ID_BIT] = id_level;
    sts_nxt[`ULRR_STS_ALT_BIT] = alt_int;
  end

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      sts_byte <= `ULRR_DATA_RST;
    else
      sts_byte <= sts_nxt;
  end

endmodule

// ### hw/ulrr_core.sv
`include "ulrr_cfg.svh"

// Behaviour
// - Low six command bits give the register address; device decodes it.
// - Device raises NXT two edges after the read command first appears.
// - Next edge: latch command, raise DIR, drop NXT together.
// - After one turnaround cycle, drive addressed register value for one cycle.
// - Next edge link samples data; device lowers DIR returning the bus.
// - Address field 2Fh requests extended read; eight-bit address follows.
// - Extended: NXT two edges after command; link drives address next edge.
// - Extended: latch address, DIR up, NXT down; drive value after turnaround.
// - Extended: link samples value as DIR drops, then drives idle.
// - Status bytes only in synchronous mode while device owns bus.
// - Schedule status byte on line state, VBUS or ID comparator change.
// - At start-up, send status byte after DIR low with STP low.
// - Leaving asynchronous modes, send status after STP low with DIR low.
// - During receive, status byte every cycle with DIR high, NXT low.
// - Status during transmit waits until STP falls; carries current status.
// - Status bits one and zero carry full-speed line state.
// - Status bits three and two encode VBUS level.
// - Status bits five and four encode receive events.
// - Status bit six reflects ID pin level.
// - Status bit seven flags a car-kit interrupt latch event.
// - One undriven turnaround cycle at each DIR change; device ignores bus.
// - Line state bit zero follows DP, bit one follows DM.
module ulrr_core
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // Bus pins
  input wire logic [7:0] data_in,
  output logic [7:0] data_out,
  output logic data_oe,
  output logic dir,
  output logic nxt,
  input wire logic stp,
  // Mode and path inputs from device logic
  input wire logic sync_mode,
  input wire logic startup_done,
  input wire logic async_exit,
  input wire logic tx_busy,
  input wire logic rx_cmd_slot,
  // Register file read port
  output logic [7:0] reg_addr,
  output logic reg_rd,
  input wire logic [7:0] reg_rdata,
  // Analog status levels from pins
  input wire logic pin_dp,
  input wire logic pin_dm,
  input wire logic pin_sess_end,
  input wire logic pin_sess_vld,
  input wire logic pin_vbus_vld,
  input wire logic pin_id,
  // Receive and interrupt status from device logic
  input wire logic rx_active,
  input wire logic rx_error,
  input wire logic host_disc,
  input wire logic alt_int,
  // Observability
  output logic sts_pending,
  output logic ext_read
);

  ulrr_pkg::ulrr_state_t state_r;
  ulrr_pkg::ulrr_state_t state_nxt;
  logic [10:0] pins_sync;
  logic [7:0] sts_byte;
  logic [5:0] cmp_prev_r;
  logic cmp_change;
  logic pend_r;
  logic startup_done_r;
  logic async_exit_r;
  logic stp_r;
  logic tx_busy_r;
  logic want_sts;
  logic is_read_cmd;
  logic is_ext_cmd;
  logic ext_r;
  logic [7:0] addr_r;
  logic start_trig;
  logic exit_trig;
  logic tx_end_trig;

  function automatic logic read_cmd(input logic [7:0] b);
    return b[`ULRR_CMD_TYPE_HI:`ULRR_CMD_TYPE_LO] == `ULRR_CMD_READ_TYPE;
  endfunction

  // Device owns the bus from the first turnaround until it releases DIR
  function automatic logic bus_owned(input ulrr_pkg::ulrr_state_t s);
    return (s == ulrr_pkg::ULRR_TURN_IN) || (s == ulrr_pkg::ULRR_DRIVE) || (s == ulrr_pkg::ULRR_STS_SEND);
  endfunction

  // Data is driven only in the cycles after the turnaround
  function automatic logic bus_driven(input ulrr_pkg::ulrr_state_t s);
    return (s == ulrr_pkg::ULRR_DRIVE) || (s == ulrr_pkg::ULRR_STS_SEND);
  endfunction

  // NXT throttles the link while command and extended address are taken
  function automatic logic nxt_phase(input ulrr_pkg::ulrr_state_t s);
    return (s == ulrr_pkg::ULRR_CMD_ACK) || (s == ulrr_pkg::ULRR_EXT_ADDR);
  endfunction

  // Analog comparators and ID come from outside the clock domain
  ulrr_sync u_sync
  (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .async_in({5'h00, pin_dp, pin_dm, pin_sess_end, pin_sess_vld, pin_vbus_vld, pin_id}),
    .sync_out(pins_sync)
  );

  ulrr_status_enc u_enc
  (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .line_dp(pins_sync[5]),
    .line_dm(pins_sync[4]),
    .sess_end(pins_sync[3]),
    .sess_vld(pins_sync[2]),
    .vbus_vld(pins_sync[1]),
    .rx_active(rx_active),
    .rx_error(rx_error),
    .host_disc(host_disc),
    .id_level(pins_sync[0]),
    .alt_int(alt_int),
    .sts_byte(sts_byte)
  );

  assign is_read_cmd = read_cmd(data_in);
  assign is_ext_cmd = data_in[`ULRR_CMD_ADDR_HI:0] == `ULRR_ADDR_ESCAPE;

  // Synchronised levels lag the pins by two edges, the status byte by one more
  // comparator change detect
  assign cmp_change = pins_sync[5:0] != cmp_prev_r;
  // start-up trigger once DIR is low and STP low
  assign start_trig = startup_done && !startup_done_r && !stp && !dir;
  // leaving async modes, STP released with DIR low
  assign exit_trig = async_exit_r && !stp && stp_r && !dir;
  assign tx_end_trig = tx_busy_r && !tx_busy && !stp;
  // only in synchronous mode, never while transmitting
  assign want_sts = pend_r && sync_mode && !tx_busy && !stp;

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      cmp_prev_r <= 6'h00;
      startup_done_r <= 1'b0;
      stp_r <= 1'b0;
      tx_busy_r <= 1'b0;
    end
    else
    begin
      cmp_prev_r <= pins_sync[5:0];
      startup_done_r <= startup_done;
      stp_r <= stp;
      tx_busy_r <= tx_busy;
    end
  end

  // Exit request is held until STP is seen released; a fresh request wins
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      async_exit_r <= 1'b0;
    else if (async_exit)
      async_exit_r <= 1'b1;
    else if (exit_trig)
      async_exit_r <= 1'b0;
  end

  // one pending flag merges all triggers; new trigger beats the clear
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      pend_r <= 1'b0;
    else if (cmp_change || start_trig || exit_trig || tx_end_trig)
      pend_r <= 1'b1;
    else if (state_r == ulrr_pkg::ULRR_STS_SEND)
      pend_r <= 1'b0;
  end

  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      // A read command wins; pending status waits for the next idle cycle
      ulrr_pkg::ULRR_IDLE:
      begin
        if (sync_mode && !dir && !stp && is_read_cmd)
          state_nxt = ulrr_pkg::ULRR_CMD_WAIT;
        else if (want_sts)
          state_nxt = ulrr_pkg::ULRR_TURN_IN;
      end
      // NXT raised on second edge after command
      ulrr_pkg::ULRR_CMD_WAIT:
        state_nxt = ulrr_pkg::ULRR_CMD_ACK;
      ulrr_pkg::ULRR_CMD_ACK:
      begin
        if (ext_r)
          state_nxt = ulrr_pkg::ULRR_EXT_ADDR;
        else
          state_nxt = ulrr_pkg::ULRR_TURN_IN;
      end
      // extended address held one more cycle under NXT
      ulrr_pkg::ULRR_EXT_ADDR:
        state_nxt = ulrr_pkg::ULRR_TURN_IN;
      ulrr_pkg::ULRR_TURN_IN:
      begin
        if (reg_rd)
          state_nxt = ulrr_pkg::ULRR_DRIVE;
        else
          state_nxt = ulrr_pkg::ULRR_STS_SEND;
      end
      ulrr_pkg::ULRR_DRIVE:
        state_nxt = ulrr_pkg::ULRR_TURN_OUT;
      // status repeats while the receive path asks
      ulrr_pkg::ULRR_STS_SEND:
      begin
        if (rx_cmd_slot)
          state_nxt = ulrr_pkg::ULRR_STS_SEND;
        else
          state_nxt = ulrr_pkg::ULRR_TURN_OUT;
      end
      ulrr_pkg::ULRR_TURN_OUT:
        state_nxt = ulrr_pkg::ULRR_IDLE;
      default:
        state_nxt = ulrr_pkg::ULRR_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      state_r <= ulrr_pkg::ULRR_IDLE;
    else
      state_r <= state_nxt;
  end

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ext_r <= 1'b0;
      addr_r <= 8'h00;
    end
    else if (state_r == ulrr_pkg::ULRR_IDLE && state_nxt == ulrr_pkg::ULRR_CMD_WAIT)
    begin
      ext_r <= is_ext_cmd;
      addr_r <= {2'h0, data_in[`ULRR_CMD_ADDR_HI:0]};
    end
    else if (state_r == ulrr_pkg::ULRR_EXT_ADDR)
      addr_r <= data_in;
  end

  // Read strobe covers turnaround, drive and release cycle; a status turnaround leaves it low
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      reg_rd <= 1'b0;
    else if (state_nxt == ulrr_pkg::ULRR_TURN_IN)
      reg_rd <= (state_r != ulrr_pkg::ULRR_IDLE);
    else if (state_r == ulrr_pkg::ULRR_TURN_OUT)
      reg_rd <= 1'b0;
  end

  // Address settles one cycle before the data is needed
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      reg_addr <= 8'h00;
    else if (state_nxt == ulrr_pkg::ULRR_TURN_IN && state_r == ulrr_pkg::ULRR_EXT_ADDR)
      reg_addr <= data_in;
    else if (state_nxt == ulrr_pkg::ULRR_TURN_IN)
      reg_addr <= addr_r;
  end

  // Pins: NXT, DIR and data come from flops decided one edge ahead
  // NXT high in the acknowledge cycles
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      nxt <= 1'b0;
    else
      nxt <= nxt_phase(state_nxt);
  end

  // DIR up with NXT down; DIR falls after one data cycle, or after the last status byte once rx_cmd_slot drops
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      dir <= 1'b0;
    else
      dir <= bus_owned(state_nxt);
  end

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      data_oe <= 1'b0;
    else
      data_oe <= bus_driven(state_nxt);
  end

  // register value; status current at send time
  // Register data is taken straight from the file while reg_addr is stable
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      data_out <= `ULRR_DATA_RST;
    else if (state_nxt == ulrr_pkg::ULRR_DRIVE)
      data_out <= reg_rdata;
    else if (state_nxt == ulrr_pkg::ULRR_STS_SEND)
      data_out <= sts_byte;
    else
      data_out <= `ULRR_IDLE_BYTE;
  end

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      sts_pending <= 1'b0;
    else
      sts_pending <= pend_r;
  end

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      ext_read <= 1'b0;
    else
      ext_read <= ext_r && (state_r != ulrr_pkg::ULRR_IDLE);
  end

endmodule

// ### testbench/ulrr_core_checker.sv
module ulrr_core_checker
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // Bus
  input wire logic [7:0] data_in,
  input wire logic [7:0] data_out,
  input wire logic data_oe,
  input wire logic dir,
  input wire logic nxt,
  input wire logic stp,
  // Control and status
  input wire logic sync_mode,
  input wire logic tx_busy,
  input wire logic rx_cmd_slot,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic ext_read
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  sequence s_take;
    dir && !nxt;
  endsequence
  sequence s_release;
    !dir && !data_oe;
  endsequence
  property p_nxt_cmd;
    $rose(nxt) |-> $past(data_in[7:6], 2) == 2'h3 && !$past(dir, 2);
  endproperty
  a_nxt_cmd: assert property (p_nxt_cmd) else $error("nxt without read command");
  property p_imm_take;
    nxt && !ext_read |=> s_take;
  endproperty
  a_imm_take: assert property (p_imm_take) else $error("dir not taken after nxt");
  property p_ext_take;
    $rose(nxt) && ext_read |=> nxt ##1 s_take;
  endproperty
  a_ext_take: assert property (p_ext_take) else $error("extended nxt timing wrong");
  property p_drive;
    $rose(dir) && reg_rd |=> data_oe && data_out == $past(reg_rdata) ##1 s_release;
  endproperty
  a_drive: assert property (p_drive) else $error("register value not driven once");
  property p_turn_in;
    $rose(dir) |-> !data_oe;
  endproperty
  a_turn_in: assert property (p_turn_in) else $error("driven in turnaround");
  property p_turn_out;
    $fell(dir) |-> !data_oe;
  endproperty
  a_turn_out: assert property (p_turn_out) else $error("driven after release");
  property p_oe_own;
    data_oe |-> dir;
  endproperty
  a_oe_own: assert property (p_oe_own) else $error("driven without dir");
  property p_sts_gate;
    $rose(dir) && !reg_rd |-> !$past(tx_busy) && !$past(stp) && $past(sync_mode);
  endproperty
  a_sts_gate: assert property (p_sts_gate) else $error("status started when blocked");
  property p_sts_slot;
    data_oe && !reg_rd && rx_cmd_slot |=> s_take and data_oe;
  endproperty
  a_sts_slot: assert property (p_sts_slot) else $error("status slot dropped");
endmodule

bind ulrr_core ulrr_core_checker ulrr_core_checker_i (.sys_clk, .rst_b, .data_in, .data_out, .data_oe, .dir,
  .nxt, .stp, .sync_mode, .tx_busy, .rx_cmd_slot, .reg_rd, .reg_rdata, .ext_read);

// ### testbench/ulrr_link_model.sv
module ulrr_link_model
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // Read request
  input wire logic req,
  input wire logic ext,
  input wire logic [7:0] addr,
  output logic [7:0] rd_data,
  output logic rd_valid,
  // Bus
  input wire logic [7:0] data_out,
  input wire logic data_oe,
  input wire logic dir,
  input wire logic nxt,
  output logic [7:0] data_bus
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] drv;
  logic [7:0] last = 8'h00;
  logic dir_q = 1'b0;
  logic nxt_q = 1'b0;
  logic [1:0] ph;
  assign data_bus = dir ? (data_oe ? data_out : ~last) : (dir_q ? ~last : drv);
  always @(posedge sys_clk)
  begin
    last <= data_bus;
    dir_q <= dir;
    nxt_q <= nxt;
  end
  always @(negedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      drv <= 8'h00;
      ph <= 2'h0;
      rd_valid <= 1'b0;
      rd_data <= 8'h00;
    end
    else
    begin
      rd_valid <= 1'b0;
      if (ph == 2'h0 && req && !dir)
      begin
        drv <= {2'h3, ext ? 6'h2F : addr[5:0]};
        ph <= 2'h1;
      end
      if (ph == 2'h1 && nxt_q)
      begin
        drv <= ext ? addr : 8'h00;
        ph <= ext ? 2'h2 : 2'h3;
      end
      if (ph == 2'h2 && dir)
      begin
        drv <= 8'h00;
        ph <= 2'h3;
      end
      if (ph == 2'h3 && data_oe)
      begin
        rd_data <= data_out;
        rd_valid <= 1'b1;
        ph <= 2'h0;
      end
    end
  end
endmodule

// ### testbench/ulpi_register_read_rxcmd_test.sv
module ulpi_register_read_rxcmd_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk = 1'b0;
  logic rst_b = 1'b0;
  logic [7:0] data_in, data_out, reg_addr, rd_data, reg_rdata;
  logic data_oe, dir, nxt, reg_rd, ext_read, rd_valid, sts_pending;
  logic stp = 1'b0, sync_mode = 1'b1, startup_done = 1'b0, async_exit = 1'b0, tx_busy = 1'b0, rx_cmd_slot = 1'b0;
  logic req = 1'b0, ext = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [9:0] pv = 10'h000;
  int num_errors = 0;
  int check_count = 0;
  // Register file stand-in
  assign reg_rdata = reg_addr ^ 8'hA5;
  initial
  begin
    forever #5 sys_clk = ~sys_clk;
  end
  ulrr_core ulrr_core_i (.sys_clk(sys_clk), .rst_b(rst_b), .data_in(data_in), .data_out(data_out),
    .data_oe(data_oe), .dir(dir), .nxt(nxt), .stp(stp), .sync_mode(sync_mode), .startup_done(startup_done),
    .async_exit(async_exit), .tx_busy(tx_busy), .rx_cmd_slot(rx_cmd_slot), .reg_addr(reg_addr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pin_dp(pv[0]), .pin_dm(pv[1]), .pin_sess_end(pv[2]),
    .pin_sess_vld(pv[3]), .pin_vbus_vld(pv[4]), .pin_id(pv[8]), .rx_active(pv[5]), .rx_error(pv[6]),
    .host_disc(pv[7]), .alt_int(pv[9]), .sts_pending(sts_pending), .ext_read(ext_read));
  ulrr_link_model ulrr_link_model_i (.sys_clk(sys_clk), .rst_b(rst_b), .req(req), .ext(ext), .addr(addr),
    .rd_data(rd_data), .rd_valid(rd_valid), .data_out(data_out), .data_oe(data_oe), .dir(dir), .nxt(nxt),
    .data_bus(data_in));
  function automatic logic [7:0] enc(input logic [9:0] v);
    logic [1:0] vb, ev;
    vb = v[4] ? 2'h3 : v[3] ? 2'h2 : v[2] ? 2'h0 : 2'h1;
    ev = v[7] ? 2'h2 : (v[5] && v[6]) ? 2'h3 : v[5] ? 2'h1 : 2'h0;
    return {v[9], v[8], ev, vb, v[1], v[0]};
  endfunction
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic quiet(input int n);
    int hi;
    hi = 0;
    repeat (n)
    begin
      @(negedge sys_clk);
      if (dir !== 1'b0) hi++;
    end
    check("dir quiet", hi[7:0], 8'h00);
  endtask
  // Missing byte returns unknown and fails the compare
  task automatic wait_sts(output logic [7:0] b);
    b = 8'hXX;
    repeat (30)
    begin
      @(negedge sys_clk);
      if (data_oe === 1'b1 && reg_rd === 1'b0)
      begin
        b = data_out;
        break;
      end
    end
  endtask
  task automatic do_read(input logic e, input logic [7:0] a);
    logic sx;
    sx = 1'b0;
    @(negedge sys_clk);
    req <= 1'b1;
    ext <= e;
    addr <= a;
    @(negedge sys_clk);
    req <= 1'b0;
    repeat (20)
    begin
      @(negedge sys_clk);
      sx = sx | (ext_read === 1'b1);
      if (rd_valid === 1'b1) break;
    end
    check("read done", {7'h00, rd_valid}, 8'h01);
    check("read data", rd_data, e ? a ^ 8'hA5 : {2'h0, a[5:0]} ^ 8'hA5);
    check("ext flag", {7'h00, sx}, {7'h00, e});
  endtask
  task automatic t_reads;
    logic [7:0] tbl [6] = '{8'h00, 8'h15, 8'h3F, 8'h80, 8'hFF, 8'h2F};
    for (int i = 0; i < 6; i++) do_read(i > 2, tbl[i]);
  endtask
  task automatic t_encode;
    logic [9:0] tbl [4] = '{10'h004, 10'h121, 10'h26A, 10'h19F};
    logic [7:0] b;
    foreach (tbl[i])
    begin
      @(negedge sys_clk);
      pv = tbl[i];
      wait_sts(b);
      check("status byte", b, enc(tbl[i]));
      quiet(12);
      check("pending clear", {7'h00, sts_pending}, 8'h00);
    end
  endtask
  task automatic t_tx_hold;
    logic [7:0] b;
    @(negedge sys_clk);
    tx_busy = 1'b1;
    pv = pv ^ 10'h001;
    quiet(6);
    pv = pv ^ 10'h002;
    quiet(6);
    check("pending held", {7'h00, sts_pending}, 8'h01);
    stp = 1'b1;
    @(negedge sys_clk);
    tx_busy = 1'b0;
    stp = 1'b0;
    wait_sts(b);
    check("held status", b, enc(pv));
  endtask
  task automatic t_slot;
    logic [7:0] b;
    @(negedge sys_clk);
    rx_cmd_slot = 1'b1;
    pv = pv ^ 10'h001;
    wait_sts(b);
    check("slot status", b, enc(pv));
    repeat (4)
    begin
      @(negedge sys_clk);
      check("slot bus", {5'h00, data_oe, dir, nxt}, 8'h06);
    end
    rx_cmd_slot = 1'b0;
    repeat (3) @(negedge sys_clk);
    check("slot end", {7'h00, dir}, 8'h00);
  endtask
  task automatic t_mode;
    logic [7:0] b;
    @(negedge sys_clk);
    sync_mode = 1'b0;
    pv = pv ^ 10'h001;
    quiet(15);
    sync_mode = 1'b1;
    wait_sts(b);
    check("mode status", b, enc(pv));
  endtask
  task automatic t_events;
    logic [7:0] b;
    @(negedge sys_clk);
    startup_done = 1'b1;
    wait_sts(b);
    check("startup status", b, enc(pv));
    quiet(8);
    stp = 1'b1;
    async_exit = 1'b1;
    @(negedge sys_clk);
    async_exit = 1'b0;
    quiet(8);
    stp = 1'b0;
    wait_sts(b);
    check("exit status", b, enc(pv));
  endtask
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial
  begin
    repeat (6) @(negedge sys_clk);
    rst_b = 1'b1;
    repeat (20) @(negedge sys_clk);
    t_reads;
    t_encode;
    t_tx_hold;
    t_slot;
    t_mode;
    t_events;
    tally_and_finish;
  end
  initial
  begin
    #100us;
    num_errors++;
    tally_and_finish;
  end
endmodule
